// ### hdl/fps_top.sv
// front-panel select/status logic: lamps, select state machine, status window, register port
module fps_top #(
	parameter int FLASH_CYC = fps_pkg::FLASH_CYC,
	parameter int SPIN_CYC  = fps_pkg::SPIN_CYC
) (
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	// register port
	input  wire logic [fps_pkg::AW-1:0] addr,
	input  wire logic [fps_pkg::DW-1:0] wr_data,
	input  wire logic                   wr_en,
	input  wire logic                   rd_en,
	output logic      [fps_pkg::DW-1:0] rd_data,
	output logic                        irq,
	// panel controls and lock status pins
	input  wire logic                   select_key,
	input  wire logic                   aux_select_key,
	input  wire logic                   knob_step_up,
	input  wire logic                   knob_step_down,
	input  wire logic                   aux_clock_locked,
	// lamps
	output logic                        external_timecode_ref_lamp,
	output logic                        varispeed_auxiliary_lamp,
	output logic                        select_key_lamp,
	output logic                        aux_select_key_lamp,
	output logic [fps_pkg::NUM_ITEMS-1:0] item_lamps,
	// status window, {g,f,e,d,c,b,a}
	output logic [6:0]                  window_seg
);
	// pin synchronisers: stage 1 feeds stage 2 only
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] sync3_r;
	wire  [4:0] pins = {aux_clock_locked, knob_step_down, knob_step_up, aux_select_key, select_key};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
			sync3_r <= 5'h00;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	wire [4:0] rise     = sync2_r & ~sync3_r;
	wire       sel_hit  = rise[0];
	wire       aux_hit  = rise[1];
	wire       step_up  = rise[2];
	wire       step_dn  = rise[3];
	wire       locked   = sync2_r[4];
	wire       lock_drop = sync3_r[4] & ~sync2_r[4];

	// register decode
	wire hit_ctrl = (addr == fps_pkg::ADDR_CTRL);
	wire hit_stat = (addr == fps_pkg::ADDR_STAT);
	wire hit_sts  = (addr == fps_pkg::ADDR_IRQ_STS);
	wire hit_mask = (addr == fps_pkg::ADDR_IRQ_MASK);

	fps_pkg::fps_ctrl_s ctrl_r;
	fps_pkg::fps_evt_s  irq_sts_r;
	fps_pkg::fps_evt_s  irq_mask_r;
	fps_pkg::fps_evt_s  evt;
	fps_pkg::fps_evt_s  sts_nxt;

	// state machine
	fps_pkg::fps_mode_e mode_r;
	fps_pkg::fps_mode_e mode_nxt;
	fps_pkg::fps_item_e item_r;
	fps_pkg::fps_item_e item_nxt;
	logic [2:0]         gpi_sel_r;
	logic [2:0]         gpi_sel_nxt;
	logic [1:0]         link_sel_r;
	logic [1:0]         link_sel_nxt;

	wire has_sec = (item_r == fps_pkg::ITEM_GPI) || (item_r == fps_pkg::ITEM_LINK);
	wire item_top = (item_r == fps_pkg::ITEM_GPI);
	wire item_bot = (item_r == fps_pkg::ITEM_OPTION_ONE);
	wire [2:0] sec_sel = (item_r == fps_pkg::ITEM_GPI) ? gpi_sel_r : {1'b0, link_sel_r};
	wire [2:0] sec_last = (item_r == fps_pkg::ITEM_GPI) ? 3'(fps_pkg::NUM_GPI - 1) : 3'(fps_pkg::NUM_LINK - 1);

	always_comb begin
		mode_nxt     = mode_r;
		item_nxt     = item_r;
		gpi_sel_nxt  = gpi_sel_r;
		link_sel_nxt = link_sel_r;
		case (mode_r)
			fps_pkg::MODE_NORMAL: begin
				if (sel_hit)
					mode_nxt = fps_pkg::MODE_SELECT;
			end
			fps_pkg::MODE_SELECT: begin
				if (sel_hit)
					mode_nxt = fps_pkg::MODE_NORMAL;
				else if (aux_hit && has_sec)
					mode_nxt = fps_pkg::MODE_AUX;
				else if (step_up && !item_top)
					item_nxt = fps_pkg::fps_item_e'(item_r + 3'h1);
				else if (step_dn && !item_bot)
					item_nxt = fps_pkg::fps_item_e'(item_r - 3'h1);
			end
			fps_pkg::MODE_AUX: begin
				if (sel_hit)
					mode_nxt = fps_pkg::MODE_SELECT;
				else if (step_up && sec_sel != sec_last) begin
					if (item_r == fps_pkg::ITEM_GPI)
						gpi_sel_nxt = gpi_sel_r + 3'h1;
					else
						link_sel_nxt = link_sel_r + 2'h1;
				end else if (step_dn && sec_sel != 3'h0) begin
					if (item_r == fps_pkg::ITEM_GPI)
						gpi_sel_nxt = gpi_sel_r - 3'h1;
					else
						link_sel_nxt = link_sel_r - 2'h1;
				end
			end
			default: mode_nxt = fps_pkg::MODE_NORMAL;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r     <= fps_pkg::MODE_NORMAL;
			item_r     <= fps_pkg::ITEM_OPTION_ONE;
			gpi_sel_r  <= 3'h0;
			link_sel_r <= 2'h0;
		end else begin
			mode_r     <= mode_nxt;
			item_r     <= item_nxt;
			gpi_sel_r  <= gpi_sel_nxt;
			link_sel_r <= link_sel_nxt;
		end
	end

	// slow enables for lamp flashing and the spinning segment
	logic [31:0] flash_cnt_r;
	logic        flash_ph_r;
	logic [31:0] spin_cnt_r;
	logic [2:0]  spin_pos_r;
	wire         flash_tick = (flash_cnt_r == 32'(FLASH_CYC - 1));
	wire         spin_tick  = (spin_cnt_r == 32'(SPIN_CYC - 1));
	wire         ffwd       = (ctrl_r.xport == fps_pkg::XP_FFWD);
	wire         rewind     = (ctrl_r.xport == fps_pkg::XP_REWIND);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt_r <= 32'h0;
			flash_ph_r  <= 1'b0;
		end else begin
			flash_cnt_r <= flash_tick ? 32'h0 : flash_cnt_r + 32'h1;
			if (flash_tick)
				flash_ph_r <= ~flash_ph_r;
		end
	end

	// six outer segments a..f; clockwise is a toward b
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			spin_cnt_r <= 32'h0;
			spin_pos_r <= 3'h0;
		end else begin
			spin_cnt_r <= spin_tick ? 32'h0 : spin_cnt_r + 32'h1;
			if (spin_tick && ffwd)
				spin_pos_r <= (spin_pos_r == 3'h5) ? 3'h0 : spin_pos_r + 3'h1;
			else if (spin_tick && rewind)
				spin_pos_r <= (spin_pos_r == 3'h0) ? 3'h5 : spin_pos_r - 3'h1;
		end
	end

	// lamps and window
	wire in_select = (mode_r == fps_pkg::MODE_SELECT);
	wire in_aux    = (mode_r == fps_pkg::MODE_AUX);
	wire external_timecode_ref_lamp_on = (ctrl_r.ref_src == fps_pkg::REF_EXTERNAL_TIMECODE_REF_LAMP);
	wire vso_on    = ctrl_r.variable_speed_override || (ctrl_r.ref_src == fps_pkg::REF_AUX);
	// an unlocked aux clock only matters when the lamp would be lit anyway
	wire vso_lamp  = vso_on && (locked || flash_ph_r);

	logic [6:0] xport_seg;
	always_comb begin
		case (ctrl_r.xport)
			fps_pkg::XP_STOP:     xport_seg = fps_pkg::SEG_S;
			fps_pkg::XP_PLAY:     xport_seg = fps_pkg::SEG_P;
			fps_pkg::XP_RECORD:   xport_seg = fps_pkg::SEG_R_UP;
			fps_pkg::XP_REHEARSE: xport_seg = fps_pkg::SEG_R_LO;
			fps_pkg::XP_FFWD,
			fps_pkg::XP_REWIND:   xport_seg = fps_pkg::SEG_SPIN0 << spin_pos_r;
			default:              xport_seg = fps_pkg::SEG_BLANK;
		endcase
	end

	// digits are one-based on the panel
	wire [6:0] sec_seg = fps_pkg::seg_digit({1'b0, sec_sel} + 4'h1);
	wire [6:0] win_nxt = (in_select || in_aux) ? (has_sec ? sec_seg : fps_pkg::SEG_BLANK) : xport_seg;

	logic [fps_pkg::NUM_ITEMS-1:0] item_lamp_nxt;
	for (genvar i = 0; i < fps_pkg::NUM_ITEMS; i++) begin : g_item
		assign item_lamp_nxt[i] = (in_select || in_aux) && (item_r == fps_pkg::fps_item_e'(i));
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			external_timecode_ref_lamp <= 1'b0;
			varispeed_auxiliary_lamp   <= 1'b0;
			select_key_lamp            <= 1'b0;
			aux_select_key_lamp        <= 1'b0;
			item_lamps                 <= '0;
			window_seg                 <= fps_pkg::SEG_BLANK;
		end else begin
			external_timecode_ref_lamp <= external_timecode_ref_lamp_on;
			varispeed_auxiliary_lamp   <= vso_lamp;
			select_key_lamp            <= in_select;
			aux_select_key_lamp        <= in_aux;
			item_lamps                 <= item_lamp_nxt;
			window_seg                 <= win_nxt;
		end
	end

	// interrupt events and register file
	assign evt.mode_moved = (mode_nxt != mode_r);
	assign evt.item_moved = (item_nxt != item_r);
	assign evt.sec_moved  = (gpi_sel_nxt != gpi_sel_r) || (link_sel_nxt != link_sel_r);
	assign evt.lock_lost  = lock_drop;
	// a new event beats a write-one-to-clear in the same cycle
	assign sts_nxt = fps_pkg::fps_evt_s'((irq_sts_r & ~((wr_en && hit_sts) ? wr_data[3:0] : 4'h0)) | evt);

	wire [fps_pkg::DW-1:0] stat_word = {19'h0, locked, 1'b0, link_sel_r, gpi_sel_r, item_r, 1'b0, mode_r};
	wire [fps_pkg::DW-1:0] rd_word =
		hit_ctrl ? {25'h0, ctrl_r} :
		hit_stat ? stat_word :
		hit_sts  ? {28'h0, irq_sts_r} :
		hit_mask ? {28'h0, irq_mask_r} : 32'h0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r     <= fps_pkg::CTRL_RST;
			irq_sts_r  <= fps_pkg::IRQ_RST;
			irq_mask_r <= fps_pkg::IRQ_RST;
			rd_data    <= 32'h0;
			irq        <= 1'b0;
		end else begin
			if (wr_en && hit_ctrl)
				ctrl_r <= fps_pkg::fps_ctrl_s'(wr_data[6:0]);
			if (wr_en && hit_mask)
				irq_mask_r <= fps_pkg::fps_evt_s'(wr_data[3:0]);
			irq_sts_r <= sts_nxt;
			rd_data   <= rd_en ? rd_word : 32'h0;
			irq       <= |(sts_nxt & irq_mask_r);
		end
	end
endmodule

// ### hdl/fps_pkg.sv
// constants, types and segment decoding for the front-panel select/status block
// Behaviour
// - External timecode lamp lit while the reference source is external time code.
// - Varispeed/aux lamp lit in variable speed override or auxiliary reference.
// - Varispeed/aux lamp flashes instead of steady while not phase-locked.
// - Select key enters select mode; its lamp is lit throughout select mode.
// - In select mode knob steps move among six primary items; item lamp lit.
// - In secondary mode knob steps move up or down through secondary items, digit updates.
// - Secondary items: eight general purpose inputs, or four downstream link ports.
// - Aux key with digit shown: select lamp off, aux lamp on, knob to secondaries.
// - Aux key ignored while the digit window is dark in select mode.
// - Select mode shows the secondary number; blank when the item has none.
// - Outside select mode window shows S, P, R or r for transport state.
// - Rotating segment clockwise in fast forward, counter-clockwise in rewind.
// - Digit shown in select mode only when the item offers secondary options.
// - Downstream link item in secondary mode: knob picks one of four ports, shown.
// - Control port 1 or 2 lamp lit when the knob lands on that port.
package fps_pkg;
	localparam int AW = 8;
	localparam int DW = 32;

	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STAT     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STS  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

	localparam int NUM_ITEMS = 6;
	localparam int NUM_GPI   = 8;
	localparam int NUM_LINK  = 4;

	// timing: the clock is given in kHz so the products stay inside 32 bits
	localparam int CLK_KHZ       = 10_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int SPIN_STEP_MS  = 100;
	localparam int FLASH_CYC     = FLASH_HALF_MS * CLK_KHZ;
	localparam int SPIN_CYC      = SPIN_STEP_MS * CLK_KHZ;

	typedef enum logic [2:0] {REF_INT_XTAL, REF_EXT_VIDEO, REF_MAINS, REF_PILOT, REF_EXTERNAL_TIMECODE_REF_LAMP, REF_AUX} fps_ref_e;
	typedef enum logic [2:0] {XP_STOP, XP_PLAY, XP_RECORD, XP_REHEARSE, XP_FFWD, XP_REWIND} fps_xport_e;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_SELECT, MODE_AUX} fps_mode_e;
	typedef enum logic [2:0] {ITEM_OPTION_ONE, ITEM_CTRL_PORT1, ITEM_CTRL_PORT2, ITEM_LINK, ITEM_SYS_REF,
		ITEM_GPI} fps_item_e;

	// control register layout, msb first
	typedef struct packed {
		fps_xport_e xport;
		logic       variable_speed_override;
		fps_ref_e   ref_src;
	} fps_ctrl_s;

	// interrupt status and mask layout
	typedef struct packed {
		logic lock_lost;
		logic sec_moved;
		logic item_moved;
		logic mode_moved;
	} fps_evt_s;

	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [3:0] IRQ_RST  = 4'h0;

	// segments are {g,f,e,d,c,b,a}
	localparam logic [6:0] SEG_BLANK = 7'h00;
	localparam logic [6:0] SEG_S     = 7'h6D;
	localparam logic [6:0] SEG_P     = 7'h73;
	localparam logic [6:0] SEG_R_UP  = 7'h77;
	localparam logic [6:0] SEG_R_LO  = 7'h50;
	localparam logic [6:0] SEG_SPIN0 = 7'h01;

	function automatic logic [6:0] seg_digit(input logic [3:0] n);
		case (n)
			4'h1: seg_digit = 7'h06;
			4'h2: seg_digit = 7'h5B;
			4'h3: seg_digit = 7'h4F;
			4'h4: seg_digit = 7'h66;
			4'h5: seg_digit = 7'h6D;
			4'h6: seg_digit = 7'h7D;
			4'h7: seg_digit = 7'h07;
			4'h8: seg_digit = 7'h7F;
			default: seg_digit = SEG_BLANK;
		endcase
	endfunction
endpackage

// ### sim/fps_checker.sv
// port-level assertions for the front-panel select/status block
module fps_checker #(
	parameter int FLASH_CYC = 8,
	parameter int SPIN_CYC  = 4
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// register port
	input wire logic [7:0]  addr,
	input wire logic [31:0] wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rd_data,
	// lamps and window
	input wire logic        external_timecode_ref_lamp,
	input wire logic        varispeed_auxiliary_lamp,
	input wire logic        select_key_lamp,
	input wire logic        aux_select_key_lamp,
	input wire logic [5:0]  item_lamps,
	input wire logic [6:0]  window_seg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence ctrl_wr;
		wr_en && addr == 8'h00;
	endsequence
	sequence tc_wr;
		ctrl_wr ##0 wr_data[2:0] == 3'h4;
	endsequence
	sequence other_wr;
		ctrl_wr ##0 wr_data[2:0] != 3'h4;
	endsequence
	// neither the override bit nor the auxiliary reference
	sequence vso_off_wr;
		ctrl_wr ##0 (!wr_data[3] && wr_data[2:0] != 3'h5);
	endsequence
	// items 3 and 5 are the only ones with secondary choices
	wire sec_item = (item_lamps & 6'h28) != 6'h00;
	AST_EXT_ON: assert property (tc_wr |-> ##2 external_timecode_ref_lamp)
		else $error("external_timecode_ref_lamp lamp not lit");
	AST_EXT_OFF: assert property (other_wr |-> ##2 !external_timecode_ref_lamp)
		else $error("external_timecode_ref_lamp lamp lit");
	AST_VSO_OFF: assert property (vso_off_wr |-> ##2 !varispeed_auxiliary_lamp)
		else $error("varispeed lamp lit");
	AST_SEL_EXCL: assert property (!(select_key_lamp && aux_select_key_lamp))
		else $error("both key lamps lit");
	AST_ITEM_ONEHOT: assert property (select_key_lamp || aux_select_key_lamp |-> $onehot(item_lamps))
		else $error("item lamps not one-hot");
	AST_ITEMS_DARK: assert property (!select_key_lamp && !aux_select_key_lamp |-> item_lamps == 6'h00)
		else $error("item lamp lit outside select");
	AST_SEL_BLANK: assert property (select_key_lamp && !sec_item |-> window_seg == 7'h00)
		else $error("window not blank");
	AST_SEL_DIGIT: assert property (select_key_lamp && sec_item |-> window_seg != 7'h00)
		else $error("digit missing");
	AST_AUX_ENTRY: assert property ($rose(aux_select_key_lamp) |-> $past(select_key_lamp)
		&& $past(window_seg) != 7'h00)
		else $error("aux entered without digit");
	AST_AUX_EXIT: assert property ($fell(aux_select_key_lamp) |-> select_key_lamp)
		else $error("aux left to a mode other than select");
	AST_LINK_RANGE: assert property (aux_select_key_lamp && item_lamps[3] |->
		window_seg inside {7'h06, 7'h5B, 7'h4F, 7'h66})
		else $error("link digit out of range");
	// first edge after release still shows the blank reset window
	AST_WIN_STATUS: assert property (!select_key_lamp && !aux_select_key_lamp && $past(rst_n) |->
		window_seg inside {7'h6D, 7'h73, 7'h77, 7'h50, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20})
		else $error("status window shows no transport character");
	AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data outside read slot");
endmodule

bind fps_top fps_checker #(.FLASH_CYC(FLASH_CYC), .SPIN_CYC(SPIN_CYC)) u_chk (
	.ref_clk                    (ref_clk),
	.rst_n                      (rst_n),
	.addr                       (addr),
	.wr_data                    (wr_data),
	.wr_en                      (wr_en),
	.rd_en                      (rd_en),
	.rd_data                    (rd_data),
	.external_timecode_ref_lamp (external_timecode_ref_lamp),
	.varispeed_auxiliary_lamp   (varispeed_auxiliary_lamp),
	.select_key_lamp            (select_key_lamp),
	.aux_select_key_lamp        (aux_select_key_lamp),
	.item_lamps                 (item_lamps),
	.window_seg                 (window_seg)
);

// ### sim/fps_panel_model.sv
// operator model: presses keys and turns the knob, one action at a time
module fps_panel_model (
	// clock
	input  wire logic ref_clk,
	// key and knob pins
	output logic      select_key,
	output logic      aux_select_key,
	output logic      knob_step_up,
	output logic      knob_step_down
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pin;
	initial pin = 4'h0;
	assign {knob_step_down, knob_step_up, aux_select_key, select_key} = pin;
	// four cycles each way so the three-flop sync sees one clean edge
	task hit(input int n);
		@(posedge ref_clk);
		pin[n] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		pin[n] <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the front-panel select/status block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FLC = 8;
	localparam int SPN = 4;
	logic        ref_clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [31:0] wr_data;
	logic        wr_en;
	logic        rd_en;
	logic        lck;
	logic [31:0] rd_data, v;
	logic        irq, sk, ak, up, dn, ext_l, vso_l, sel_l, aux_l;
	logic [5:0]  items;
	logic [6:0]  seg;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cnt;
	// {ctrl, ext lamp, vso lamp, window}
	logic [16:0] rows [4] = '{{8'h00, 2'b00, 7'h6D}, {8'h14, 2'b10, 7'h73}, {8'h28, 2'b01, 7'h77},
		{8'h35, 2'b01, 7'h50}};
	always #50 ref_clk = ~ref_clk;
	fps_top #(.FLASH_CYC(FLC), .SPIN_CYC(SPN)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .select_key(sk),
		.aux_select_key(ak), .knob_step_up(up), .knob_step_down(dn), .aux_clock_locked(lck),
		.external_timecode_ref_lamp(ext_l), .varispeed_auxiliary_lamp(vso_l), .select_key_lamp(sel_l),
		.aux_select_key_lamp(aux_l), .item_lamps(items), .window_seg(seg));
	fps_panel_model p (.ref_clk(ref_clk), .select_key(sk), .aux_select_key(ak), .knob_step_up(up),
		.knob_step_down(dn));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		v = rd_data;
	endtask
	// samples mid-step so the spin phase does not matter
	task spin(input logic [7:0] c, input logic cw);
		logic [6:0] s;
		int k;
		wr(8'h00, {24'h0, c});
		repeat (3) @(posedge ref_clk);
		#1;
		s = seg;
		k = 0;
		while (seg === s && k < 20) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		repeat (SPN / 2) @(posedge ref_clk);
		#1;
		s = seg;
		repeat (SPN) @(posedge ref_clk);
		#1;
		chk(seg, cw ? (s == 7'h20 ? 7'h01 : s << 1) : (s == 7'h01 ? 7'h20 : s >> 1));
	endtask
	task close_out();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		close_out();
	end
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		lck = 1'b1;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, {24'h0, rows[i][16:9]});
			repeat (2) @(posedge ref_clk);
			#1;
			chk({ext_l, vso_l, seg}, rows[i][8:0]);
		end
		wr(8'h00, 32'h05);
		lck <= 1'b0;
		repeat (10) @(posedge ref_clk);
		cnt = 0;
		repeat (4 * FLC) begin
			@(posedge ref_clk);
			#1;
			cnt += vso_l;
		end
		chk(cnt > 8 && cnt < 24, 1'b1);
		@(posedge ref_clk);
		lck <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		chk(vso_l, 1'b1);
		spin(8'h40, 1'b1);
		spin(8'h50, 1'b0);
		wr(8'h00, 32'h0);
		wr(8'h0C, 32'h1);
		p.hit(0);
		chk({sel_l, items, seg}, {1'b1, 6'h01, 7'h00});
		chk(irq, 1'b1);
		rd(8'h08);
		chk(v[0], 1'b1);
		wr(8'h08, 32'hF);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(irq, 1'b0);
		p.hit(1);
		chk(aux_l, 1'b0);
		p.hit(3);
		chk(items, 6'h01);
		for (int i = 1; i < 4; i++) begin
			p.hit(2);
			chk(items, 6'h01 << i);
		end
		chk(seg, 7'h06);
		p.hit(1);
		chk({sel_l, aux_l, seg}, {2'b01, 7'h06});
		repeat (5) p.hit(2);
		chk(seg, 7'h66);
		rd(8'h04);
		chk(v, 32'h161A);
		p.hit(0);
		chk({sel_l, items}, {1'b1, 6'h08});
		repeat (2) p.hit(2);
		chk({items, seg}, {6'h20, 7'h06});
		p.hit(1);
		p.hit(2);
		chk(seg, 7'h5B);
		repeat (8) p.hit(2);
		chk(seg, 7'h7F);
		wr(8'h0C, 32'h0);
		p.hit(0);
		p.hit(0);
		chk({items, seg, irq}, {6'h00, 7'h6D, 1'b0});
		rd(8'h10);
		chk(v, 32'h0);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk({sel_l, aux_l, items, seg, ext_l, vso_l, irq}, 18'h0);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(seg, 7'h6D);
		close_out();
	end
endmodule
